// ---- verilog/dsw_pkg.sv ----
// Shared constants and types of the distance switch output logic
package dsw_pkg;

	// Widths and counts
	localparam int DSW_DIST_W = 16;
	localparam int DSW_ADDR_W = 8;
	localparam int DSW_DATA_W = 32;
	localparam int DSW_NUM_SW = 2;
	localparam int DSW_STEP_W = 4;

	// Global register offsets (byte addresses)
	localparam logic [7:0] DSW_OFS_CTRL     = 8'h00;
	localparam logic [7:0] DSW_OFS_STATUS   = 8'h04;
	localparam logic [7:0] DSW_OFS_LASTDIST = 8'h08;

	// Per-switch pages: address bits 7:5 pick the switch, bits 4:0 the field
	localparam logic [2:0] DSW_PAGE_SW1 = 3'h1;
	localparam logic [2:0] DSW_PAGE_SW2 = 3'h2;
	localparam logic [4:0] DSW_FLD_CFG      = 5'h00;
	localparam logic [4:0] DSW_FLD_SETPOINT = 5'h04;
	localparam logic [4:0] DSW_FLD_HYST     = 5'h08;
	localparam logic [4:0] DSW_FLD_NEAR     = 5'h0c;
	localparam logic [4:0] DSW_FLD_FAR      = 5'h10;

	// Control register fields
	localparam int DSW_CTRL_SEL_LSB  = 0;
	localparam int DSW_CTRL_SEL_W    = 2;
	localparam int DSW_CTRL_BTN_DIS  = 2;
	localparam int DSW_CTRL_SYNC_MST = 3;
	localparam int DSW_CTRL_SYNC_SLV = 4;

	// Switch configuration fields
	localparam int DSW_CFG_MODE  = 0;
	localparam int DSW_CFG_POL   = 1;
	localparam int DSW_CFG_PWRUP = 2;
	localparam int DSW_CFG_NOTGT = 3;

	// Encodings
	localparam logic [1:0] DSW_SEL_NONE      = 2'h0;
	localparam logic [1:0] DSW_SEL_ONE       = 2'h1;
	localparam logic [1:0] DSW_SEL_TWO       = 2'h2;
	localparam logic       DSW_MODE_SETPOINT = 1'h0;
	localparam logic       DSW_MODE_WINDOW   = 1'h1;

	// Reset values; polarity bit i belongs to switch i (0 = on closer / on in window)
	localparam logic [1:0]            DSW_SEL_RST      = DSW_SEL_NONE;
	localparam logic                  DSW_BTN_DIS_RST  = 1'h0;
	localparam logic                  DSW_SYNC_RST     = 1'h0;
	localparam logic [1:0]            DSW_POL_RST      = 2'h2;
	localparam logic                  DSW_PWRUP_RST    = 1'h0;
	localparam logic                  DSW_NOTGT_RST    = 1'h0;
	localparam logic [DSW_DIST_W-1:0] DSW_SETPOINT_RST = 16'h0100;
	localparam logic [DSW_DIST_W-1:0] DSW_HYST_RST     = 16'h0004;
	localparam logic [DSW_DIST_W-1:0] DSW_FAR_RST      = DSW_SETPOINT_RST + DSW_HYST_RST;

	// Learn step codes
	localparam logic [DSW_STEP_W-1:0] DSW_LEARN_SP1  = 4'h7;
	localparam logic [DSW_STEP_W-1:0] DSW_LEARN_POL1 = 4'h8;
	localparam logic [DSW_STEP_W-1:0] DSW_LEARN_SP2  = 4'h9;
	localparam logic [DSW_STEP_W-1:0] DSW_LEARN_POL2 = 4'ha;

	// Bus answer state
	typedef enum logic {
		DSW_BUS_IDLE = 1'h0,
		DSW_BUS_ACK  = 1'h1
	} dsw_bus_t;

endpackage : dsw_pkg

// ---- verilog/dsw_sync.sv ----
// Two-stage synchroniser for pin inputs
module dsw_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	import dsw_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	always_comb begin
		next_stage1  = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stage1  <= '0;
			syncOut <= '0;
		end else begin
			stage1  <= next_stage1;
			syncOut <= next_syncOut;
		end
	end

endmodule : dsw_sync

// ---- verilog/dsw_switch.sv ----
// Decision logic of one switch output
module dsw_switch #(
	parameter int DIST_W = dsw_pkg::DSW_DIST_W
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Measurement results
	input  wire logic              measDone,
	input  wire logic [DIST_W-1:0] measDist,
	input  wire logic              measValid,
	input  wire logic              noTargetExpired,
	// Settings
	input  wire logic              cfgMode,
	input  wire logic              cfgPol,
	input  wire logic              cfgPowerUp,
	input  wire logic              cfgNoTarget,
	input  wire logic [DIST_W-1:0] setpoint,
	input  wire logic [DIST_W-1:0] hysteresis,
	input  wire logic [DIST_W-1:0] windowNear,
	input  wire logic [DIST_W-1:0] windowFar,
	// State
	output logic                   swState,
	output logic                   started
);
	import dsw_pkg::*;

	logic            next_swState;
	logic            next_started;
	logic [DIST_W:0] spPlusHyst;
	logic [DIST_W:0] distPlusHyst;
	logic            inWindow;

	always_comb begin
		spPlusHyst   = {1'b0, setpoint} + {1'b0, hysteresis};
		distPlusHyst = {1'b0, measDist} + {1'b0, hysteresis};
		inWindow     = (measDist >= windowNear) && (measDist <= windowFar);
		next_swState = swState;
		next_started = started;
		if (!started && !measDone) begin
			next_swState = cfgPowerUp;
		end
		if (measDone) begin
			next_started = 1'b1;
			if (measValid) begin
				if (cfgMode == DSW_MODE_WINDOW) begin
					next_swState = inWindow ^ cfgPol;
				end else if (!cfgPol) begin
					// On closer: on at the setpoint, off once back out by the hysteresis
					if (measDist <= setpoint) begin
						next_swState = 1'b1;
					end else if ({1'b0, measDist} >= spPlusHyst) begin
						next_swState = 1'b0;
					end
				end else begin
					if (measDist >= setpoint) begin
						next_swState = 1'b1;
					end else if (distPlusHyst <= {1'b0, setpoint}) begin
						next_swState = 1'b0;
					end
				end
			end else if (noTargetExpired) begin
				next_swState = cfgNoTarget;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			swState <= 1'b0;
			started <= 1'b0;
		end else begin
			swState <= next_swState;
			started <= next_started;
		end
	end

	sequence sqEval;
		measDone && measValid;
	endsequence

	a_powerup_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!started && !measDone) |=> (swState == $past(cfgPowerUp)))
		else $error("power-up level not held");

	a_hyst_closer_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sqEval and (cfgMode == DSW_MODE_SETPOINT && !cfgPol && measDist <= setpoint)) |=> swState)
		else $error("closer switch not on at setpoint");

	a_hyst_band_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sqEval and (cfgMode == DSW_MODE_SETPOINT && !cfgPol && measDist > setpoint
			&& {1'b0, measDist} < spPlusHyst)) |=> $stable(swState))
		else $error("switch changed inside hysteresis band");

	a_hyst_farther_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sqEval and (cfgMode == DSW_MODE_SETPOINT && cfgPol && distPlusHyst <= {1'b0, setpoint}))
		|=> !swState)
		else $error("farther switch not off below band");

	a_window_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sqEval and (cfgMode == DSW_MODE_WINDOW && measDist >= windowNear && measDist <= windowFar))
		|=> (swState == !$past(cfgPol)))
		else $error("window state wrong inside window");

	a_no_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(measDone && !measValid && noTargetExpired) |=> (swState == $past(cfgNoTarget)))
		else $error("no-target level not applied");

	a_idle_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(started && !measDone) |=> $stable(swState))
		else $error("switch changed without measurement");

endmodule : dsw_switch

// ---- verilog/dsw_top.sv ----
// Distance switch output logic with Avalon-MM register access
// Contract
// - Setpoint mode: on at setpoint, off only after moving back by the hysteresis.
// - Window mode: state follows whether distance lies between near and far limits.
// - Setpoint polarity picks on-closer or on-farther; switch one closer, two farther.
// - Window polarity picks on or off while the target is inside the window.
// - Each switch holds its power-up level, default off, until the first measurement.
// - Setpoint is the off-to-on distance; learn 7 captures switch one, 9 switch two.
// - Learn 8 inverts switch one polarity, learn 10 inverts switch two polarity.
// - A control bit can disable the learn button; it defaults to enabled.
// - Learn button always works in sync master or sync slave operation.
// - Zero, one or two outputs selectable, default none; switch one on line one.
// - Per-switch level applied when no target seen for the qualifying period.
// - Learning a new near limit shifts the far limit to keep window width.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module dsw_top #(
	parameter int DIST_W = dsw_pkg::DSW_DIST_W
) (
	// Clock and reset
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	// Avalon-MM slave
	input  wire logic [dsw_pkg::DSW_ADDR_W-1:0]      avsAddress,
	input  wire logic                                avsRead,
	input  wire logic                                avsWrite,
	input  wire logic [dsw_pkg::DSW_DATA_W-1:0]      avsWritedata,
	output logic      [dsw_pkg::DSW_DATA_W-1:0]      avsReaddata,
	output logic                                     avsWaitrequest,
	// Measurement engine
	input  wire logic                                measDone,
	input  wire logic [DIST_W-1:0]                   measDist,
	input  wire logic                                measValid,
	input  wire logic                                noTargetExpired,
	// Learn push-button front end (pins)
	input  wire logic                                learnPinStrobe,
	input  wire logic [dsw_pkg::DSW_STEP_W-1:0]      learnPinStep,
	// Switch output lines
	output logic                                     swLineOne,
	output logic                                     swLineTwo
);
	import dsw_pkg::*;

	localparam int NSW = DSW_NUM_SW;

	// Control state
	logic [1:0]        outSelect;
	logic              buttonDisable;
	logic              syncMaster;
	logic              syncSlave;
	logic [NSW-1:0]    cfgMode;
	logic [NSW-1:0]    cfgPol;
	logic [NSW-1:0]    cfgPowerUp;
	logic [NSW-1:0]    cfgNoTarget;
	logic [DIST_W-1:0] setpoint   [NSW];
	logic [DIST_W-1:0] hysteresis [NSW];
	logic [DIST_W-1:0] windowNear [NSW];
	logic [DIST_W-1:0] windowFar  [NSW];
	logic [1:0]        next_outSelect;
	logic              next_buttonDisable;
	logic              next_syncMaster;
	logic              next_syncSlave;
	logic [NSW-1:0]    next_cfgMode;
	logic [NSW-1:0]    next_cfgPol;
	logic [NSW-1:0]    next_cfgPowerUp;
	logic [NSW-1:0]    next_cfgNoTarget;
	logic [DIST_W-1:0] next_setpoint   [NSW];
	logic [DIST_W-1:0] next_hysteresis [NSW];
	logic [DIST_W-1:0] next_windowNear [NSW];
	logic [DIST_W-1:0] next_windowFar  [NSW];

	// Last valid distance, used by learn capture
	logic              haveDist;
	logic [DIST_W-1:0] lastDist;
	logic              next_haveDist;
	logic [DIST_W-1:0] next_lastDist;

	// Learn front end
	logic [DSW_STEP_W:0] learnSync;
	logic                learnPrev;
	logic                next_learnPrev;
	logic                learnRise;
	logic                learnAllowed;
	logic                learnFire;
	logic [DSW_STEP_W-1:0] learnStep;

	// Bus
	dsw_bus_t                busState;
	dsw_bus_t                next_busState;
	logic                    next_avsWaitrequest;
	logic [DSW_DATA_W-1:0]   next_avsReaddata;
	logic                    wrCommit;

	// Switches and lines
	logic [NSW-1:0] swState;
	logic [NSW-1:0] swStarted;
	logic           next_swLineOne;
	logic           next_swLineTwo;

	// Switch index of a per-switch page, or NSW when not a switch page
	function automatic int swIndex(input logic [DSW_ADDR_W-1:0] addr);
		if (addr[7:5] == DSW_PAGE_SW1) begin
			return 0;
		end
		if (addr[7:5] == DSW_PAGE_SW2) begin
			return 1;
		end
		return NSW;
	endfunction : swIndex

	// Zero-extend a distance into a bus word
	function automatic logic [DSW_DATA_W-1:0] distWord(input logic [DIST_W-1:0] d);
		return {{(DSW_DATA_W-DIST_W){1'b0}}, d};
	endfunction : distWord

	// Read mux; unmapped addresses read as zero
	function automatic logic [DSW_DATA_W-1:0] regRead(input logic [DSW_ADDR_W-1:0] addr);
		logic [DSW_DATA_W-1:0] r;
		int                    i;
		r = '0;
		i = swIndex(addr);
		if (addr == DSW_OFS_CTRL) begin
			r[DSW_CTRL_SEL_LSB +: DSW_CTRL_SEL_W] = outSelect;
			r[DSW_CTRL_BTN_DIS]  = buttonDisable;
			r[DSW_CTRL_SYNC_MST] = syncMaster;
			r[DSW_CTRL_SYNC_SLV] = syncSlave;
		end else if (addr == DSW_OFS_STATUS) begin
			r[1:0] = swState;
			r[3:2] = swStarted;
			r[4]   = swLineOne;
			r[5]   = swLineTwo;
			r[6]   = learnAllowed;
		end else if (addr == DSW_OFS_LASTDIST) begin
			r       = distWord(lastDist);
			r[31]   = haveDist;
		end else if (i < NSW) begin
			case (addr[4:0])
				DSW_FLD_CFG: begin
					r[DSW_CFG_MODE]  = cfgMode[i];
					r[DSW_CFG_POL]   = cfgPol[i];
					r[DSW_CFG_PWRUP] = cfgPowerUp[i];
					r[DSW_CFG_NOTGT] = cfgNoTarget[i];
				end
				DSW_FLD_SETPOINT: r = distWord(setpoint[i]);
				DSW_FLD_HYST:     r = distWord(hysteresis[i]);
				DSW_FLD_NEAR:     r = distWord(windowNear[i]);
				DSW_FLD_FAR:      r = distWord(windowFar[i]);
				default:          r = '0;
			endcase
		end
		return r;
	endfunction : regRead

	// Step code settles before the strobe, so sampling it on the synced strobe edge is safe
	dsw_sync #(
		.WIDTH (DSW_STEP_W + 1)
	) uLearnSync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.asyncIn ({learnPinStrobe, learnPinStep}),
		.syncOut (learnSync)
	);

	always_comb begin
		next_learnPrev = learnSync[DSW_STEP_W];
		learnRise      = learnSync[DSW_STEP_W] && !learnPrev;
		learnStep      = learnSync[DSW_STEP_W-1:0];
		learnAllowed   = !buttonDisable || syncMaster || syncSlave;
		learnFire      = learnRise && learnAllowed;
	end

	// Bus answer: waitrequest drops one cycle after the request, write commits at the next edge, where it is sampled low
	always_comb begin
		next_busState       = busState;
		next_avsWaitrequest = 1'b1;
		next_avsReaddata    = avsReaddata;
		wrCommit            = 1'b0;
		case (busState)
			DSW_BUS_IDLE: begin
				if (avsRead || avsWrite) begin
					next_busState       = DSW_BUS_ACK;
					next_avsWaitrequest = 1'b0;
					next_avsReaddata    = avsRead ? regRead(avsAddress) : '0;
				end
			end
			DSW_BUS_ACK: begin
				wrCommit      = avsWrite;
				next_busState = DSW_BUS_IDLE;
			end
			default: begin
				next_busState = DSW_BUS_IDLE;
			end
		endcase
	end

	// Settings: software writes first, learn applied after so it wins on a clash
	always_comb begin
		int                i;
		logic [DIST_W-1:0] shift;
		i                  = swIndex(avsAddress);
		shift              = '0;
		next_outSelect     = outSelect;
		next_buttonDisable = buttonDisable;
		next_syncMaster    = syncMaster;
		next_syncSlave     = syncSlave;
		next_cfgMode       = cfgMode;
		next_cfgPol        = cfgPol;
		next_cfgPowerUp    = cfgPowerUp;
		next_cfgNoTarget   = cfgNoTarget;
		next_setpoint      = setpoint;
		next_hysteresis    = hysteresis;
		next_windowNear    = windowNear;
		next_windowFar     = windowFar;
		if (wrCommit) begin
			if (avsAddress == DSW_OFS_CTRL) begin
				next_outSelect     = avsWritedata[DSW_CTRL_SEL_LSB +: DSW_CTRL_SEL_W];
				next_buttonDisable = avsWritedata[DSW_CTRL_BTN_DIS];
				next_syncMaster    = avsWritedata[DSW_CTRL_SYNC_MST];
				next_syncSlave     = avsWritedata[DSW_CTRL_SYNC_SLV];
			end else if (i < NSW) begin
				case (avsAddress[4:0])
					DSW_FLD_CFG: begin
						next_cfgMode[i]     = avsWritedata[DSW_CFG_MODE];
						next_cfgPol[i]      = avsWritedata[DSW_CFG_POL];
						next_cfgPowerUp[i]  = avsWritedata[DSW_CFG_PWRUP];
						next_cfgNoTarget[i] = avsWritedata[DSW_CFG_NOTGT];
					end
					DSW_FLD_SETPOINT: next_setpoint[i]   = avsWritedata[DIST_W-1:0];
					DSW_FLD_HYST:     next_hysteresis[i] = avsWritedata[DIST_W-1:0];
					DSW_FLD_NEAR:     next_windowNear[i] = avsWritedata[DIST_W-1:0];
					DSW_FLD_FAR:      next_windowFar[i]  = avsWritedata[DIST_W-1:0];
					default: begin
					end
				endcase
			end
		end
		if (learnFire) begin
			case (learnStep)
				DSW_LEARN_POL1: next_cfgPol[0] = !cfgPol[0];
				DSW_LEARN_POL2: next_cfgPol[1] = !cfgPol[1];
				default: begin
				end
			endcase
			// Capture is skipped until a valid distance has been seen
			for (int k = 0; k < NSW; k++) begin
				if (haveDist && learnStep == (k == 0 ? DSW_LEARN_SP1 : DSW_LEARN_SP2)) begin
					shift              = lastDist - windowNear[k];
					next_setpoint[k]   = lastDist;
					next_windowNear[k] = lastDist;
					next_windowFar[k]  = windowFar[k] + shift;
				end
			end
		end
	end

	always_comb begin
		next_haveDist = haveDist;
		next_lastDist = lastDist;
		if (measDone && measValid) begin
			next_haveDist = 1'b1;
			next_lastDist = measDist;
		end
		next_swLineOne = (outSelect >= DSW_SEL_ONE) && swState[0];
		next_swLineTwo = (outSelect >= DSW_SEL_TWO) && swState[1];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busState       <= DSW_BUS_IDLE;
			avsWaitrequest <= 1'b1;
			avsReaddata    <= '0;
			learnPrev      <= 1'b0;
			outSelect      <= DSW_SEL_RST;
			buttonDisable  <= DSW_BTN_DIS_RST;
			syncMaster     <= DSW_SYNC_RST;
			syncSlave      <= DSW_SYNC_RST;
			cfgMode        <= {NSW{DSW_MODE_SETPOINT}};
			cfgPol         <= DSW_POL_RST;
			cfgPowerUp     <= {NSW{DSW_PWRUP_RST}};
			cfgNoTarget    <= {NSW{DSW_NOTGT_RST}};
			for (int k = 0; k < NSW; k++) begin
				setpoint[k]   <= DSW_SETPOINT_RST;
				hysteresis[k] <= DSW_HYST_RST;
				windowNear[k] <= DSW_SETPOINT_RST;
				windowFar[k]  <= DSW_FAR_RST;
			end
			haveDist       <= 1'b0;
			lastDist       <= '0;
			swLineOne      <= 1'b0;
			swLineTwo      <= 1'b0;
		end else begin
			busState       <= next_busState;
			avsWaitrequest <= next_avsWaitrequest;
			avsReaddata    <= next_avsReaddata;
			learnPrev      <= next_learnPrev;
			outSelect      <= next_outSelect;
			buttonDisable  <= next_buttonDisable;
			syncMaster     <= next_syncMaster;
			syncSlave      <= next_syncSlave;
			cfgMode        <= next_cfgMode;
			cfgPol         <= next_cfgPol;
			cfgPowerUp     <= next_cfgPowerUp;
			cfgNoTarget    <= next_cfgNoTarget;
			setpoint       <= next_setpoint;
			hysteresis     <= next_hysteresis;
			windowNear     <= next_windowNear;
			windowFar      <= next_windowFar;
			haveDist       <= next_haveDist;
			lastDist       <= next_lastDist;
			swLineOne      <= next_swLineOne;
			swLineTwo      <= next_swLineTwo;
		end
	end

	for (genvar g = 0; g < NSW; g++) begin : gSwitch
		dsw_switch #(
			.DIST_W (DIST_W)
		) uSwitch (
			.sys_clk         (sys_clk),
			.rst_n           (rst_n),
			.measDone        (measDone),
			.measDist        (measDist),
			.measValid       (measValid),
			.noTargetExpired (noTargetExpired),
			.cfgMode         (cfgMode[g]),
			.cfgPol          (cfgPol[g]),
			.cfgPowerUp      (cfgPowerUp[g]),
			.cfgNoTarget     (cfgNoTarget[g]),
			.setpoint        (setpoint[g]),
			.hysteresis      (hysteresis[g]),
			.windowNear      (windowNear[g]),
			.windowFar       (windowFar[g]),
			.swState         (swState[g]),
			.started         (swStarted[g])
		);
	end

	sequence sqLearnSp1;
		learnFire && haveDist && learnStep == DSW_LEARN_SP1;
	endsequence

	sequence sqBusReq;
		busState == DSW_BUS_IDLE && (avsRead || avsWrite);
	endsequence

	a_learn_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sqLearnSp1 |=> (setpoint[0] == $past(lastDist)) && (windowNear[0] == $past(lastDist)))
		else $error("learn did not capture setpoint");

	a_learn_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sqLearnSp1 |=> (DIST_W'(windowFar[0] - windowNear[0])
			== DIST_W'($past(windowFar[0]) - $past(windowNear[0]))))
		else $error("window width changed by learn");

	a_learn_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(learnFire && learnStep == DSW_LEARN_POL2) |=> (cfgPol[1] != $past(cfgPol[1])))
		else $error("learn did not invert polarity");

	a_learn_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(learnRise && buttonDisable && !syncMaster && !syncSlave && !wrCommit) |=> $stable(cfgPol))
		else $error("disabled button changed polarity");

	a_learn_sync_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(learnRise && (syncMaster || syncSlave)) |-> learnFire)
		else $error("button refused in sync operation");

	a_line_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(outSelect == DSW_SEL_NONE) |=> (!swLineOne && !swLineTwo))
		else $error("line driven with no output selected");

	a_line_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(outSelect == DSW_SEL_TWO) |=> (swLineTwo == $past(swState[1])))
		else $error("line two does not follow switch two");

	a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sqBusReq |=> !avsWaitrequest ##1 avsWaitrequest)
		else $error("bus answer not one cycle");

endmodule : dsw_top

// ---- tb/test_distance_switch_output_logic.sv ----
// Self-checking bench of the distance switch output logic
module test_distance_switch_output_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import dsw_pkg::*;

	localparam logic [7:0] CFG1 = {DSW_PAGE_SW1, DSW_FLD_CFG};
	localparam logic [7:0] CFG2 = {DSW_PAGE_SW2, DSW_FLD_CFG};
	localparam logic [7:0] SP1  = {DSW_PAGE_SW1, DSW_FLD_SETPOINT};
	localparam logic [7:0] SP2  = {DSW_PAGE_SW2, DSW_FLD_SETPOINT};
	localparam logic [7:0] NR1  = {DSW_PAGE_SW1, DSW_FLD_NEAR};
	localparam logic [7:0] FAR1 = {DSW_PAGE_SW1, DSW_FLD_FAR};

	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  avsAddress = 8'h00;
	logic        avsRead = 1'b0;
	logic        avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic        avsWaitrequest;
	logic        measDone = 1'b0;
	logic [15:0] measDist = 16'h0;
	logic        measValid = 1'b0;
	logic        noTargetExpired = 1'b0;
	logic        learnPinStrobe = 1'b0;
	logic [3:0]  learnPinStep = 4'h0;
	logic        swLineOne;
	logic        swLineTwo;
	int          failCount = 0;
	int          samplesChecked = 0;
	int          cycles = 0;
	logic [15:0] hd [6] = '{16'h0105, 16'h0100, 16'h00fd, 16'h00fc, 16'h0103, 16'h0104};
	logic [1:0]  he [6] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h3, 2'h1};

	dsw_top i_dsw_top (.sys_clk(sys_clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .measDone(measDone), .measDist(measDist), .measValid(measValid),
		.noTargetExpired(noTargetExpired), .learnPinStrobe(learnPinStrobe), .learnPinStep(learnPinStep),
		.swLineOne(swLineOne), .swLineTwo(swLineTwo));

	always #4 sys_clk = ~sys_clk;

	task conclude();
		$display("mismatches %0d, comparisons %0d", failCount, samplesChecked);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// Hang guard, well above the few hundred cycles the sequence needs
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failCount = failCount + 1;
			$display("unexpected at %0t: timeout, sequence did not finish", $time);
			conclude();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked = samplesChecked + 1;
		if (got !== exp) begin
			failCount = failCount + 1;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is sampled low at an edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= 1'b1;
		do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
		avsWrite <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		avsAddress <= a;
		avsRead <= 1'b1;
		do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
		avsRead <= 1'b0;
		chk(avsReaddata, exp);
	endtask : rd

	// Lines settle two edges after the measurement pulse
	task ms(input logic [15:0] d, input logic v, input logic [1:0] e);
		@(posedge sys_clk);
		measDone <= 1'b1;
		measDist <= d;
		measValid <= v;
		@(posedge sys_clk);
		measDone <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk({30'h0, swLineOne, swLineTwo}, {30'h0, e});
	endtask : ms

	// Step code settles through the synchroniser before the strobe rises
	task learn(input logic [3:0] s);
		@(posedge sys_clk);
		learnPinStep <= s;
		repeat (4) @(posedge sys_clk);
		learnPinStrobe <= 1'b1;
		repeat (6) @(posedge sys_clk);
		learnPinStrobe <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : learn

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk({30'h0, swLineOne, swLineTwo}, 32'h0);
		rd(DSW_OFS_CTRL, 32'h0);
		rd(CFG1, 32'h0);
		rd(CFG2, 32'h2);
		rd(SP1, 32'h100);
		rd(FAR1, 32'h104);
		rd(8'h0c, 32'h0);
		wr(DSW_OFS_CTRL, 32'h2);
		wr(CFG1, 32'h4);
		repeat (3) @(posedge sys_clk);
		chk({30'h0, swLineOne, swLineTwo}, 32'h2);
		for (int i = 0; i < 6; i++) begin
			ms(hd[i], 1'b1, he[i]);
		end
		// States 2'b10, both started, line two up, learn allowed
		rd(DSW_OFS_STATUS, 32'h6e);
		wr(DSW_OFS_CTRL, 32'h1);
		ms(16'h0100, 1'b1, 2'h2);
		wr(DSW_OFS_CTRL, 32'h3);
		wr(CFG1, 32'h1);
		wr(CFG2, 32'h3);
		ms(16'h00ff, 1'b1, 2'h1);
		ms(16'h0102, 1'b1, 2'h2);
		ms(16'h0104, 1'b1, 2'h2);
		ms(16'h0105, 1'b1, 2'h1);
		wr(CFG1, 32'h9);
		ms(16'h0102, 1'b0, 2'h1);
		noTargetExpired <= 1'b1;
		ms(16'h0102, 1'b0, 2'h2);
		noTargetExpired <= 1'b0;
		learn(DSW_LEARN_POL1);
		rd(CFG1, 32'hb);
		learn(DSW_LEARN_POL2);
		rd(CFG2, 32'h1);
		rd(DSW_OFS_LASTDIST, 32'h80000105);
		learn(DSW_LEARN_SP1);
		rd(SP1, 32'h105);
		rd(NR1, 32'h105);
		rd(FAR1, 32'h109);
		learn(DSW_LEARN_SP2);
		rd(SP2, 32'h105);
		// A step code outside the learn set must leave every setting alone
		learn(4'h3);
		rd(CFG1, 32'hb);
		rd(CFG2, 32'h1);
		wr(DSW_OFS_CTRL, 32'h6);
		learn(DSW_LEARN_POL1);
		rd(CFG1, 32'hb);
		wr(DSW_OFS_CTRL, 32'he);
		learn(DSW_LEARN_POL1);
		rd(CFG1, 32'h9);
		wr(DSW_OFS_CTRL, 32'h16);
		learn(DSW_LEARN_POL1);
		rd(CFG1, 32'hb);
		// Mid-run reset must bring settings and lines back to their defaults
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk({30'h0, swLineOne, swLineTwo}, 32'h0);
		rd(DSW_OFS_CTRL, 32'h0);
		rd(CFG1, 32'h0);
		rd(CFG2, 32'h2);
		rd(SP1, 32'h100);
		conclude();
	end
endmodule : test_distance_switch_output_logic
